/* core/pief_cfg.svh */
// register map, bit positions, masks and reset values of the peripheral interrupt block
`ifndef PIEF_CFG_SVH
`define PIEF_CFG_SVH

// ==========================================================================
// register offsets (byte address on the register port)
`define PIEF_OFS_CTRL 8'h00
`define PIEF_OFS_ENA_A 8'h01
`define PIEF_OFS_ENA_B 8'h02
`define PIEF_OFS_FLAG_A 8'h03
`define PIEF_OFS_FLAG_B 8'h04
`define PIEF_OFS_PEND_A 8'h05
`define PIEF_OFS_PEND_B 8'h06

// ==========================================================================
// main control bits
`define PIEF_BIT_GIE 7
`define PIEF_BIT_PERIPH_GROUP_ENABLE 6

// ==========================================================================
// first pair: enable and flag share positions
`define PIEF_BIT_ADC 6
`define PIEF_BIT_BCL 5
`define PIEF_BIT_SSP 4
`define PIEF_BIT_TMR2 1
`define PIEF_BIT_TMR1 0

// ==========================================================================
// second pair: enable and flag share positions
`define PIEF_BIT_UV 7
`define PIEF_BIT_OC 5
`define PIEF_BIT_OV 4
`define PIEF_BIT_VIN 1

// ==========================================================================
// implemented-bit masks and reset values
`define PIEF_MASK_CTRL 8'hC0
`define PIEF_MASK_A 8'h73
`define PIEF_MASK_B 8'hB2
`define PIEF_RST_CTRL 8'h00
`define PIEF_RST_A 8'h00
`define PIEF_RST_B 8'h00
`define PIEF_ZERO 8'h00

`endif

/* core/pief_pkg.sv */
// types shared by the peripheral interrupt block
`default_nettype none
package pief_pkg;

  // ========================================================================
  // register width and address width
  typedef logic [7:0] pief_byte_type;
  typedef logic [7:0] pief_addr_type;

  // ========================================================================
  // decoded register selection
  typedef enum logic [2:0] {
    PIEF_SEL_NONE = 3'h0,
    PIEF_SEL_CTRL = 3'h1,
    PIEF_SEL_ENA_A = 3'h2,
    PIEF_SEL_ENA_B = 3'h3,
    PIEF_SEL_FLAG_A = 3'h4,
    PIEF_SEL_FLAG_B = 3'h5,
    PIEF_SEL_PEND_A = 3'h6,
    PIEF_SEL_PEND_B = 3'h7
  } pief_sel_type;

endpackage : pief_pkg
`default_nettype wire

/* core/pief_bit_reg.sv */
// eight-bit register with masked bits, software write and hardware set
`timescale 1ns/1ps
`default_nettype none
module pief_bit_reg #(
  parameter logic [7:0] IMPL_MASK = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] set_vec,
  output logic [7:0] q
);

  // ========================================================================
  // storage: a hardware set is ORed in last so it wins over a clear;
  // unimplemented positions are forced to zero on every path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= RESET_VAL & IMPL_MASK;
    end else if (wr_en) begin
      q <= (wr_data | set_vec) & IMPL_MASK;
    end else begin
      q <= (q | set_vec) & IMPL_MASK;
    end
  end

endmodule : pief_bit_reg
`default_nettype wire

/* core/pief_top.sv */
// peripheral interrupt enable and flag registers with request gating
//
// Summary of operation
// - no peripheral request without group enable
// - first enable register gates five sources
// - second enable: bits 7,5,4,1, reset zero
// - unimplemented bits read zero, ignore writes
// - flags set regardless of any enable
// - adc flag set on conversion done
// - serial flags show pending events
// - timer2 match flag sticky until written zero
// - timer1 rollover flag sticky until written zero
// - global enable cleared blocks every request
// - second flags mirror second enable positions
`timescale 1ns/1ps
`default_nettype none
`include "pief_cfg.svh"
module pief_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire pief_pkg::pief_addr_type reg_addr,
  input wire pief_pkg::pief_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pief_pkg::pief_byte_type reg_rdata,
  input wire logic adc_done_evt,
  input wire logic bus_collision_evt,
  input wire logic serial_port_evt,
  input wire logic timer2_match_evt,
  input wire logic timer1_rollover_evt,
  input wire logic out_undervolt_evt,
  input wire logic out_overcurrent_evt,
  input wire logic out_overvolt_evt,
  input wire logic input_uvlo_evt,
  output logic periph_irq_req,
  output logic global_irq_enable,
  output logic periph_group_enable
);
  import pief_pkg::*;

  // ========================================================================
  // internal signals
  pief_sel_type wr_sel;
  pief_sel_type rd_sel;
  logic wr_ctrl;
  logic wr_ena_a;
  logic wr_ena_b;
  logic wr_flag_a;
  logic wr_flag_b;
  pief_byte_type main_irq_control;
  pief_byte_type periph_irq_enable_a;
  pief_byte_type periph_irq_enable_b;
  pief_byte_type periph_irq_flag_a;
  pief_byte_type periph_irq_flag_b;
  pief_byte_type set_flag_a;
  pief_byte_type set_flag_b;
  pief_byte_type pend_a;
  pief_byte_type pend_b;
  pief_byte_type next_rdata;
  logic next_irq_req;

  // ========================================================================
  // address decode
  function automatic pief_sel_type pief_decode(input pief_addr_type addr);
    pief_sel_type sel;
    sel = PIEF_SEL_NONE;
    unique case (addr)
      `PIEF_OFS_CTRL: sel = PIEF_SEL_CTRL;
      `PIEF_OFS_ENA_A: sel = PIEF_SEL_ENA_A;
      `PIEF_OFS_ENA_B: sel = PIEF_SEL_ENA_B;
      `PIEF_OFS_FLAG_A: sel = PIEF_SEL_FLAG_A;
      `PIEF_OFS_FLAG_B: sel = PIEF_SEL_FLAG_B;
      `PIEF_OFS_PEND_A: sel = PIEF_SEL_PEND_A;
      `PIEF_OFS_PEND_B: sel = PIEF_SEL_PEND_B;
      default: sel = PIEF_SEL_NONE;
    endcase
    return sel;
  endfunction : pief_decode

  // write and read selection from the strobes
  always_comb begin
    wr_sel = reg_wr ? pief_decode(reg_addr) : PIEF_SEL_NONE;
    rd_sel = reg_rd ? pief_decode(reg_addr) : PIEF_SEL_NONE;
  end

  // one write enable per writable register; pending views take no write
  assign wr_ctrl = (wr_sel == PIEF_SEL_CTRL);
  assign wr_ena_a = (wr_sel == PIEF_SEL_ENA_A);
  assign wr_ena_b = (wr_sel == PIEF_SEL_ENA_B);
  assign wr_flag_a = (wr_sel == PIEF_SEL_FLAG_A);
  assign wr_flag_b = (wr_sel == PIEF_SEL_FLAG_B);

  // ========================================================================
  // event vectors, placed at the flag positions
  always_comb begin
    set_flag_a = `PIEF_ZERO;
    set_flag_a[`PIEF_BIT_ADC] = adc_done_evt;
    set_flag_a[`PIEF_BIT_BCL] = bus_collision_evt;
    set_flag_a[`PIEF_BIT_SSP] = serial_port_evt;
    set_flag_a[`PIEF_BIT_TMR2] = timer2_match_evt;
    set_flag_a[`PIEF_BIT_TMR1] = timer1_rollover_evt;
  end

  // analog fault events share positions with the second enable register
  always_comb begin
    set_flag_b = `PIEF_ZERO;
    set_flag_b[`PIEF_BIT_UV] = out_undervolt_evt;
    set_flag_b[`PIEF_BIT_OC] = out_overcurrent_evt;
    set_flag_b[`PIEF_BIT_OV] = out_overvolt_evt;
    set_flag_b[`PIEF_BIT_VIN] = input_uvlo_evt;
  end

  // ========================================================================
  // main control: only the global and group enables live here
  pief_bit_reg #(
    .IMPL_MASK(`PIEF_MASK_CTRL),
    .RESET_VAL(`PIEF_RST_CTRL)
  ) u_ctrl (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_ctrl),
    .wr_data(reg_wdata),
    .set_vec(`PIEF_ZERO),
    .q(main_irq_control)
  );

  // ========================================================================
  // first enable register, masked to the five source positions
  pief_bit_reg #(
    .IMPL_MASK(`PIEF_MASK_A),
    .RESET_VAL(`PIEF_RST_A)
  ) u_ena_a (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_ena_a),
    .wr_data(reg_wdata),
    .set_vec(`PIEF_ZERO),
    .q(periph_irq_enable_a)
  );

  // second enable register, fault enables only, cleared at reset
  pief_bit_reg #(
    .IMPL_MASK(`PIEF_MASK_B),
    .RESET_VAL(`PIEF_RST_B)
  ) u_ena_b (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_ena_b),
    .wr_data(reg_wdata),
    .set_vec(`PIEF_ZERO),
    .q(periph_irq_enable_b)
  );

  // ========================================================================
  // first flag register: events set, software writes zero to clear
  pief_bit_reg #(
    .IMPL_MASK(`PIEF_MASK_A),
    .RESET_VAL(`PIEF_RST_A)
  ) u_flag_a (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_flag_a),
    .wr_data(reg_wdata),
    .set_vec(set_flag_a),
    .q(periph_irq_flag_a)
  );

  // second flag register: fault events set, software writes zero to clear
  pief_bit_reg #(
    .IMPL_MASK(`PIEF_MASK_B),
    .RESET_VAL(`PIEF_RST_B)
  ) u_flag_b (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(wr_flag_b),
    .wr_data(reg_wdata),
    .set_vec(set_flag_b),
    .q(periph_irq_flag_b)
  );

  // ========================================================================
  // pending sources: flag and enable at the same position
  assign pend_a = periph_irq_flag_a & periph_irq_enable_a;
  assign pend_b = periph_irq_flag_b & periph_irq_enable_b;

  // request gated by group and global enables; stale flags fire at once,
  // so software must clear them before enabling
  always_comb begin
    next_irq_req = (|pend_a) | (|pend_b);
    next_irq_req = next_irq_req & main_irq_control[`PIEF_BIT_PERIPH_GROUP_ENABLE];
    next_irq_req = next_irq_req & main_irq_control[`PIEF_BIT_GIE];
  end

  // registered request toward the core
  always_ff @(posedge core_clk) begin
    if (srst) begin
      periph_irq_req <= 1'b0;
    end else begin
      periph_irq_req <= next_irq_req;
    end
  end

  // registered copies of the two enables for the core
  always_ff @(posedge core_clk) begin
    if (srst) begin
      global_irq_enable <= 1'b0;
      periph_group_enable <= 1'b0;
    end else begin
      global_irq_enable <= main_irq_control[`PIEF_BIT_GIE];
      periph_group_enable <= main_irq_control[`PIEF_BIT_PERIPH_GROUP_ENABLE];
    end
  end

  // ========================================================================
  // read mux: unmapped offsets and idle cycles return zero
  always_comb begin
    next_rdata = `PIEF_ZERO;
    unique case (rd_sel)
      PIEF_SEL_NONE: next_rdata = `PIEF_ZERO;
      PIEF_SEL_CTRL: next_rdata = main_irq_control;
      PIEF_SEL_ENA_A: next_rdata = periph_irq_enable_a;
      PIEF_SEL_ENA_B: next_rdata = periph_irq_enable_b;
      PIEF_SEL_FLAG_A: next_rdata = periph_irq_flag_a;
      PIEF_SEL_FLAG_B: next_rdata = periph_irq_flag_b;
      PIEF_SEL_PEND_A: next_rdata = pend_a;
      PIEF_SEL_PEND_B: next_rdata = pend_b;
    endcase
  end

  // read data stands for exactly the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= `PIEF_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : pief_top
`default_nettype wire

/* dv/pief_event_src.sv */
// model of the peripheral event sources feeding the interrupt block
`timescale 1ns/1ps
`default_nettype none
module pief_event_src (
  input wire logic core_clk,
  output logic [8:0] evt
);
  // all sources quiet until a condition is raised
  initial evt = 9'h000;
  // one-cycle condition on source n, launched just after a clock edge
  task automatic fire(input int n);
    @(posedge core_clk);
    evt[n] <= 1'b1;
    @(posedge core_clk);
    evt[n] <= 1'b0;
  endtask : fire
endmodule : pief_event_src
`default_nettype wire

/* dv/pief_top_assertions.sv */
// port-level checker of the peripheral interrupt block
`timescale 1ns/1ps
`default_nettype none
module pief_top_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer1_rollover_evt,
  input wire logic periph_irq_req,
  input wire logic global_irq_enable,
  input wire logic periph_group_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // request needs both enable copies up
  property p_req_gated;
    periph_irq_req |-> global_irq_enable && periph_group_enable;
  endproperty
  a_req_gated: assert property (p_req_gated) else $error("request while gated");
  // without a write nothing can drop a pending request
  property p_req_hold;
    periph_irq_req && !$past(reg_wr) |=> periph_irq_req;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  // read data stand only after a read
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  // control writes reach the enable copies two edges later
  property p_gie_on;
    reg_wr && reg_addr == 8'h00 && reg_wdata[7] |-> ##2 global_irq_enable;
  endproperty
  a_gie_on: assert property (p_gie_on) else $error("global enable not set");
  property p_periph_group_enable_off;
    reg_wr && reg_addr == 8'h00 && !reg_wdata[6] |-> ##2 !periph_group_enable;
  endproperty
  a_periph_group_enable_off: assert property (p_periph_group_enable_off) else $error("group enable not cleared");
  // unmapped and unimplemented places read zero
  property p_unmapped;
    reg_rd && reg_addr > 8'h06 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_a;
    reg_rd && (reg_addr == 8'h01 || reg_addr == 8'h03) |=> (reg_rdata & 8'h8C) == 8'h00;
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("first pair spare bit set");
  property p_mask_b;
    reg_rd && (reg_addr == 8'h02 || reg_addr == 8'h04) |=> (reg_rdata & 8'h4D) == 8'h00;
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("second pair spare bit set");
  // a rollover shows in the flag read two edges later
  property p_evt_flag;
    reg_rd && reg_addr == 8'h03 && $past(timer1_rollover_evt, 2) && !$past(reg_wr)
      |=> reg_rdata[0];
  endproperty
  a_evt_flag: assert property (p_evt_flag) else $error("rollover flag missing");
endmodule : pief_top_assertions
bind pief_top pief_top_assertions i_pief_top_assertions (.core_clk, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer1_rollover_evt, .periph_irq_req,
  .global_irq_enable, .periph_group_enable);
`default_nettype wire

/* dv/testbench.sv */
// self-checking testbench of the peripheral interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pief_pkg::*;
  logic core_clk, srst, reg_wr, reg_rd;
  pief_addr_type reg_addr;
  pief_byte_type reg_wdata, reg_rdata;
  logic periph_irq_req, global_irq_enable, periph_group_enable;
  wire logic [8:0] evt;
  int fail_count = 0;
  int checks = 0;
  localparam logic [7:0] SRC_MASK [9] = '{8'h40, 8'h20, 8'h10, 8'h02, 8'h01, 8'h80, 8'h20,
    8'h10, 8'h02};
  pief_top i_pief_top (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_done_evt(evt[0]), .bus_collision_evt(evt[1]), .serial_port_evt(evt[2]),
    .timer2_match_evt(evt[3]), .timer1_rollover_evt(evt[4]), .out_undervolt_evt(evt[5]),
    .out_overcurrent_evt(evt[6]), .out_overvolt_evt(evt[7]), .input_uvlo_evt(evt[8]),
    .periph_irq_req(periph_irq_req), .global_irq_enable(global_irq_enable),
    .periph_group_enable(periph_group_enable));
  pief_event_src i_pief_event_src (.core_clk(core_clk), .evt(evt));
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd_chk
  // request level once flag and request registers have settled
  task automatic req_chk(input string what, input logic exp);
    repeat (2) @(posedge core_clk);
    #1;
    chk(what, {7'h00, exp}, {7'h00, periph_irq_req});
  endtask : req_chk
  // all writable bits set, spare bits and the unmapped offset stay clear
  task automatic t_masks;
    logic [7:0] exp [8] = '{8'hC0, 8'h73, 8'hB2, 8'h73, 8'hB2, 8'h73, 8'hB2, 8'h00};
    for (int a = 0; a < 8; a++) wr(a == 7 ? 8'h20 : 8'(a), 8'hFF);
    for (int a = 0; a < 8; a++) rd_chk("mask", a == 7 ? 8'h20 : 8'(a), exp[a]);
    for (int a = 0; a < 5; a++) wr(8'(a), 8'h00);
  endtask : t_masks
  // every source sets its flag with all source enables clear and both control enables set
  task automatic t_flags_free;
    wr(8'h00, 8'hC0);
    for (int i = 0; i < 9; i++) i_pief_event_src.fire(i);
    req_chk("blocked req", 1'b0);
    rd_chk("flag a", 8'h03, 8'h73);
    rd_chk("flag b", 8'h04, 8'hB2);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h00);
    rd_chk("flag a clear", 8'h03, 8'h00);
  endtask : t_flags_free
  // each source alone raises and holds the request until its flag is cleared
  task automatic t_each;
    logic [7:0] ra;
    for (int i = 0; i < 9; i++) begin
      ra = i < 5 ? 8'h01 : 8'h02;
      wr(ra + 8'h02, 8'h00);
      wr(ra, SRC_MASK[i]);
      i_pief_event_src.fire(i);
      req_chk("source req", 1'b1);
      req_chk("held req", 1'b1);
      wr(ra + 8'h02, 8'h00);
      req_chk("cleared req", 1'b0);
      wr(ra, 8'h00);
    end
  endtask : t_each
  // group and global enables each block a pending request
  task automatic t_gate;
    wr(8'h01, 8'h01);
    i_pief_event_src.fire(4);
    rd_chk("rollover flag", 8'h03, 8'h01);
    rd_chk("pending a", 8'h05, 8'h01);
    wr(8'h00, 8'h80);
    req_chk("no group", 1'b0);
    chk("global copy on", 8'h01, {7'h00, global_irq_enable});
    wr(8'h00, 8'h40);
    req_chk("no global", 1'b0);
    chk("global copy off", 8'h00, {7'h00, global_irq_enable});
    chk("group copy", 8'h01, {7'h00, periph_group_enable});
    wr(8'h00, 8'hC0);
    req_chk("both on", 1'b1);
    wr(8'h03, 8'h00);
    req_chk("flag cleared", 1'b0);
    // a rollover in the same cycle as a clearing write keeps the flag set
    fork
      wr(8'h03, 8'h00);
      i_pief_event_src.fire(4);
    join
    rd_chk("set wins", 8'h03, 8'h01);
  endtask : t_gate
  // verdict
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watchdog far beyond the few hundred cycles of the run
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 7; a++) rd_chk("reset", 8'(a), 8'h00);
    t_masks();
    t_flags_free();
    t_each();
    t_gate();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
